// ---- bench/hsq_ctrl_test.sv ----
`timescale 1ns/1ps
module hsq_ctrl_test;
    import hsq_pkg::*;
    localparam logic [22:0] LOCK_N  = 23'h14;
    localparam logic [22:0] START_N = 23'h28;
    logic        pclk = 1'b0, presetn = 1'b0, look = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hC3D6;
    logic        pready, pslverr, mode_hi_in = 1'b0, mode_lo_in = 1'b0, gnd = 1'b0;
    logic [3:0]  supply_up = 4'h0, short_req = 4'h0, surge_req = 4'h0, enable_in = 4'h0;
    logic [3:0]  lockout_in, rail_in, fast_oc_in, slow_oc_in, gate_en, ramp_limit, good_flag;
    logic [35:0] exp_q[$];
    int          fails = 0, check_count = 0;

    always #4 pclk = ~pclk;

    hsq_ctrl #(.LOCKOUT_CYCLES(LOCK_N), .START_DEF_CYCLES(START_N)) u_hsq_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lockout_in(lockout_in), .rail_in(rail_in), .enable_in(enable_in),
        .fast_oc_in(fast_oc_in), .slow_oc_in(slow_oc_in), .mode_hi_in(mode_hi_in),
        .mode_lo_in(mode_lo_in), .flag_sense_select_gnd(gnd), .gate_en(gate_en),
        .ramp_limit(ramp_limit), .good_flag(good_flag));

    hsq_front_model u_hsq_front_model (
        .pclk(pclk), .supply_up(supply_up), .short_req(short_req), .surge_req(surge_req),
        .gate_en(gate_en), .lockout_in(lockout_in), .rail_in(rail_in),
        .fast_oc_in(fast_oc_in), .slow_oc_in(slow_oc_in));

    function automatic logic [31:0] next_rnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // status word: good, fault, start, gates, lock done, fixed, mode
    function automatic logic [35:0] st(input logic [1:0] m, input logic [3:0] g,
                                       input logic [3:0] f, input logic [3:0] ok);
        return {16'h0, ok, f, 4'h0, g, 2'b11, m};
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next call never reassigns psel in this step
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [35:0] want);
        exp_q.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask

    // expected good pattern is given as asserted; polarity applied here
    task automatic pins(input logic [3:0] g, input logic [3:0] r, input logic [3:0] ok);
        exp_q.push_back({24'h0, g, r, ok ^ {4{gnd}}});
        look <= 1'b1;
        @(posedge pclk);
        look <= 1'b0;
    endtask

    task automatic restart(input logic hi, input logic lo, input logic g);
        presetn <= 1'b0;
        supply_up <= 4'h0;
        enable_in <= 4'h0;
        mode_hi_in <= hi;
        mode_lo_in <= lo;
        gnd <= g;
        tick(5);
        presetn <= 1'b1;
        supply_up <= 4'hF;
        tick(LOCK_N + 8);
        pins(4'h0, 4'h0, 4'h0);
    endtask

    // results are compared as they appear, oldest note first
    always @(posedge pclk) begin
        if ((psel & penable & pready & ~pwrite) === 1'b1 || look) begin
            if (exp_q.size() == 0) check(36'h1, 36'h0);
            else if (look) check({24'h0, gate_en, ramp_limit, good_flag}, exp_q.pop_front());
            else check({3'h0, pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        #(8 * 90000);
        fails++;
        finish_test();
    end

    initial begin
        // tracking
        restart(1'b1, 1'b0, 1'b0);
        rd(REG_STATUS, st(2'd0, 4'h0, 4'h0, 4'h0));
        rd(REG_START, {13'h0, START_N});
        rd(8'h0C, {4'h1, 32'h0});
        mode_hi_in <= 1'b0;
        mode_lo_in <= 1'b1;
        enable_in <= 4'h7;
        tick(8);
        pins(4'h0, 4'h0, 4'h0);
        enable_in <= 4'hF;
        tick(6);
        pins(4'hF, 4'h0, 4'h0);
        surge_req <= 4'h4;
        tick(6);
        pins(4'hF, 4'h0, 4'h0);
        surge_req <= 4'h0;
        short_req <= 4'h2;
        tick(6);
        pins(4'hF, 4'h2, 4'h0);
        short_req <= 4'h0;
        tick(40);
        pins(4'hF, 4'h0, 4'hF);
        rnd = next_rnd(rnd);
        apb(1'b1, REG_STATUS, rnd);
        rd(REG_STATUS, st(2'd0, 4'hF, 4'h0, 4'hF));
        enable_in <= 4'hB;
        tick(6);
        pins(4'h0, 4'h0, 4'h0);
        enable_in <= 4'hF;
        tick(50);
        short_req <= 4'h2;
        tick(8);
        short_req <= 4'h0;
        tick(100);
        pins(4'h0, 4'h0, 4'h0);
        rd(REG_STATUS, st(2'd0, 4'h0, 4'h2, 4'h0));
        enable_in <= 4'hE;
        tick(12500);
        enable_in <= 4'hF;
        tick(50);
        pins(4'hF, 4'h0, 4'hF);
        // sequencing
        restart(1'b0, 1'b0, 1'b0);
        rd(REG_STATUS, st(2'd1, 4'h0, 4'h0, 4'h0));
        for (int i = 0; i < 6; i++) begin
            rnd = next_rnd(rnd);
            enable_in <= rnd[3:0];
            tick(60);
            pins(rnd[3:0], 4'h0, rnd[3:0]);
        end
        enable_in <= 4'hF;
        supply_up <= 4'h7;
        tick(8);
        pins(4'h0, 4'h0, 4'h0);
        supply_up <= 4'hF;
        tick(60);
        short_req <= 4'h8;
        tick(8);
        short_req <= 4'h0;
        pins(4'h0, 4'h0, 4'h0);
        enable_in <= 4'hD;
        tick(12500);
        enable_in <= 4'hB;
        tick(60);
        pins(4'hB, 4'h0, 4'hB);
        // independent, flags active low
        restart(1'b0, 1'b1, 1'b1);
        rd(REG_STATUS, st(2'd2, 4'h0, 4'h0, 4'h0));
        rd(REG_CTRL, 36'h0);
        supply_up <= 4'hE;
        enable_in <= 4'hF;
        tick(60);
        pins(4'hE, 4'h0, 4'hE);
        short_req <= 4'h4;
        tick(8);
        short_req <= 4'h0;
        pins(4'hA, 4'h0, 4'hA);
        enable_in <= 4'hB;
        tick(12500);
        enable_in <= 4'hF;
        tick(60);
        pins(4'hE, 4'h0, 4'hE);
        apb(1'b1, REG_CTRL, 32'h1);
        rd(REG_CTRL, 36'h1);
        short_req <= 4'h8;
        tick(8);
        short_req <= 4'h0;
        tick(64 * 40 - 200);
        pins(4'h6, 4'h0, 4'h6);
        tick(300);
        pins(4'hE, 4'h0, 4'hE);
        apb(1'b1, REG_START, 32'h00000005);
        rd(REG_START, {13'h0, START_MIN_CYC});
        rnd = next_rnd(rnd);
        apb(1'b1, REG_START, rnd | 32'h00700000);
        rd(REG_START, {13'h0, START_MAX_CYC});
        tick(4);
        if (exp_q.size() != 0) fails++;
        finish_test();
    end
endmodule // hsq_ctrl_test

// ---- bench/hsq_front_model.sv ----
`timescale 1ns/1ps
module hsq_front_model (
    // clock
    input  wire logic       pclk,
    // board commands from the bench
    input  wire logic [3:0] supply_up,
    input  wire logic [3:0] short_req,
    input  wire logic [3:0] surge_req,
    // gate drive seen from the board
    input  wire logic [3:0] gate_en,
    // comparator levels
    output logic      [3:0] lockout_in,
    output logic      [3:0] rail_in,
    output logic      [3:0] fast_oc_in,
    output logic      [3:0] slow_oc_in
);
    initial begin
        lockout_in = 4'h0;
        rail_in    = 4'h0;
        fast_oc_in = 4'h0;
        slow_oc_in = 4'h0;
    end

    // load current only flows through a switch that is on
    always @(posedge pclk) begin
        lockout_in <= supply_up;
        rail_in    <= supply_up;
        fast_oc_in <= short_req & gate_en;
        slow_oc_in <= surge_req & gate_en;
    end
endmodule // hsq_front_model

// ---- verilog/hsq_ctrl.sv ----
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module hsq_ctrl #(
    parameter logic [22:0] LOCKOUT_CYCLES   = hsq_pkg::LOCKOUT_CYC,
    parameter logic [22:0] START_DEF_CYCLES = hsq_pkg::START_DEF_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // comparator results and straps
    input  wire logic [3:0]  lockout_in,
    input  wire logic [3:0]  rail_in,
    input  wire logic [3:0]  enable_in,
    input  wire logic [3:0]  fast_oc_in,
    input  wire logic [3:0]  slow_oc_in,
    input  wire logic        mode_hi_in,
    input  wire logic        mode_lo_in,
    input  wire logic        flag_sense_select_gnd,
    // channel outputs
    output logic [3:0]       gate_en,
    output logic [3:0]       ramp_limit,
    output logic [3:0]       good_flag
);
    import hsq_pkg::*;

    hsq_sync_if sy ();

    hsq_sync u_sync (
        .pclk              (pclk),
        .presetn           (presetn),
        .lockout_in        (lockout_in),
        .rail_in           (rail_in),
        .enable_in         (enable_in),
        .fast_oc_in        (fast_oc_in),
        .slow_oc_in        (slow_oc_in),
        .mode_hi_in        (mode_hi_in),
        .mode_lo_in        (mode_lo_in),
        .flag_sense_gnd_in (flag_sense_select_gnd),
        .sy                (sy.src)
    );

    // registers
    logic          auto_q, auto_d;
    logic [22:0]   len_q, len_d;
    logic [31:0]   rd_q, rd_d;
    hsq_mode_type  mode_q, mode_d;
    logic          fixed_q, fixed_d;
    logic          lock_q, lock_d;
    logic [3:0]    en_prev_q;
    logic [3:0]    gate_q, gate_d;
    logic [3:0]    ilim_q, ilim_d;
    logic [3:0]    good_q, good_d;
    logic [3:0]    stat_q, stat_d;
    hsq_chan_type  st_q [NCH];
    hsq_chan_type  st_d [NCH];
    // combinational
    logic          any_lock, lock_exp, wr, mapped;
    logic [3:0]    en_fall, flt, trip, cond, clr, texp, tload;
    logic [TW-1:0] tval [NCH];
    logic [TW-1:0] start_val, retry_val;

    assign any_lock  = |sy.lockout_level;
    assign en_fall   = en_prev_q & ~sy.enable_level;
    assign start_val = {6'h00, len_q};
    assign retry_val = {len_q, 6'h00};

    // lockout delay: held loaded while every input sits below the level
    hsq_timer u_lock (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (!any_lock),
        .value   ({6'h00, LOCKOUT_CYCLES}),
        .expire  (lock_exp)
    );

    for (genvar g = 0; g < NCH; g++) begin : g_tmr
        hsq_timer u_tmr (
            .pclk    (pclk),
            .presetn (presetn),
            .load    (tload[g]),
            .value   (tval[g]),
            .expire  (texp[g])
        );
    end

    // mode strap and lockout tracking
    always_comb begin
        mode_d  = mode_q;
        fixed_d = fixed_q;
        lock_d  = lock_q;
        if (!fixed_q && any_lock) begin
            mode_d  = hsq_decode_mode(sy.mode_hi, sy.mode_lo);
            fixed_d = 1'b1;
        end
        if (!any_lock)
            lock_d = 1'b0;
        else if (lock_exp)
            lock_d = 1'b1;
    end

    // turn-on conditions per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            flt[i]  = (st_q[i] == CH_FAULT) || (st_q[i] == CH_RETRY);
            // slow comparator only counts once the window is over
            trip[i] = (st_q[i] == CH_RUN) && (sy.fast_oc[i] || sy.slow_oc[i]);
        end
        for (int i = 0; i < NCH; i++) begin
            case (mode_q)
                MODE_TRACK: begin
                    cond[i] = lock_q && (&sy.rail_present_level)
                              && (&sy.enable_level) && !(|(flt | trip));
                    clr[i]  = |en_fall;
                end
                MODE_SEQ: begin
                    cond[i] = lock_q && (&sy.rail_present_level)
                              && sy.enable_level[i] && !(|(flt | trip));
                    clr[i]  = |en_fall;
                end
                MODE_INDEP: begin
                    cond[i] = lock_q && sy.rail_present_level[i]
                              && sy.enable_level[i] && !flt[i] && !trip[i];
                    clr[i]  = en_fall[i];
                end
                default: begin
                    cond[i] = 1'b0;
                    clr[i]  = 1'b0;
                end
            endcase
            // lost lockout must drop gates in the same cycle lock_q clears
            cond[i] = cond[i] && fixed_q && any_lock;
        end
    end

    // channel state machines
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            st_d[i]  = st_q[i];
            tload[i] = 1'b0;
            tval[i]  = start_val;
            case (st_q[i])
                CH_OFF:
                    if (cond[i]) begin
                        st_d[i]  = CH_START;
                        tload[i] = 1'b1;
                    end
                CH_START:
                    if (!cond[i])
                        st_d[i] = CH_OFF;
                    else if (texp[i])
                        st_d[i] = CH_RUN;
                CH_RUN:
                    if (trip[i])
                        st_d[i] = CH_FAULT;
                    else if (!cond[i])
                        st_d[i] = CH_OFF;
                CH_FAULT:
                    if (clr[i])
                        st_d[i] = CH_OFF;
                    else if (auto_q) begin
                        st_d[i]  = CH_RETRY;
                        tload[i] = 1'b1;
                        tval[i]  = retry_val;
                    end
                CH_RETRY:
                    if (clr[i] || texp[i])
                        st_d[i] = CH_OFF;
                default:
                    st_d[i] = CH_OFF;
            endcase
        end
    end

    // outputs follow the next state so pins and state agree
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            gate_d[i] = (st_d[i] == CH_START) || (st_d[i] == CH_RUN);
            ilim_d[i] = (st_d[i] == CH_START) && sy.fast_oc[i];
            good_d[i] = (st_d[i] == CH_RUN) && sy.enable_level[i];
        end
        stat_d = good_d ^ {4{sy.flag_sense_gnd}};
    end

    // apb: zero wait states, read data captured in the setup cycle
    assign wr     = psel && penable && pwrite;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_START) || (paddr == REG_STATUS);

    always_comb begin
        auto_d = auto_q;
        len_d  = len_q;
        rd_d   = rd_q;
        if (wr && paddr == REG_CTRL)
            auto_d = pwdata[CTRL_AUTO_BIT];
        if (wr && paddr == REG_START)
            len_d = hsq_clamp_len(pwdata[22:0]);
        if (psel && !penable && !pwrite) begin
            rd_d = 32'h00000000;
            case (paddr)
                REG_CTRL:  rd_d[CTRL_AUTO_BIT] = auto_q;
                REG_START: rd_d[22:0] = len_q;
                REG_STATUS: begin
                    rd_d[ST_MODE_LSB +: 2]  = mode_q;
                    rd_d[ST_FIXED_BIT]      = fixed_q;
                    rd_d[ST_LOCK_BIT]       = lock_q;
                    rd_d[ST_GATE_LSB +: 4]  = gate_q;
                    rd_d[ST_START_LSB +: 4] = ilim_q | {(st_q[3] == CH_START),
                        (st_q[2] == CH_START), (st_q[1] == CH_START), (st_q[0] == CH_START)};
                    rd_d[ST_FAULT_LSB +: 4] = flt;
                    rd_d[ST_GOOD_LSB +: 4]  = good_q;
                end
                default: rd_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_q    <= CTRL_AUTO_RST;
            len_q     <= START_DEF_CYCLES;
            rd_q      <= 32'h00000000;
            mode_q    <= MODE_SEQ;
            fixed_q   <= 1'b0;
            lock_q    <= 1'b0;
            en_prev_q <= 4'h0;
            gate_q    <= 4'h0;
            ilim_q    <= 4'h0;
            good_q    <= 4'h0;
            stat_q    <= 4'h0;
            for (int i = 0; i < NCH; i++)
                st_q[i] <= CH_OFF;
        end else begin
            auto_q    <= auto_d;
            len_q     <= len_d;
            rd_q      <= rd_d;
            mode_q    <= mode_d;
            fixed_q   <= fixed_d;
            lock_q    <= lock_d;
            en_prev_q <= sy.enable_level;
            gate_q    <= gate_d;
            ilim_q    <= ilim_d;
            good_q    <= good_d;
            stat_q    <= stat_d;
            for (int i = 0; i < NCH; i++)
                st_q[i] <= st_d[i];
        end
    end

    assign prdata     = rd_q;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped;
    assign gate_en    = gate_q;
    assign ramp_limit = ilim_q;
    assign good_flag  = stat_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_mode_frozen: assert property (fixed_q |=> fixed_q && mode_q == $past(mode_q))
        else $error("mode changed after it was fixed");
    chk_gate_needs_delay: assert property (|gate_q |-> fixed_q && lock_q)
        else $error("gate on before lockout delay");
    chk_track_together: assert property (mode_q == MODE_TRACK |-> gate_q == 4'h0 || gate_q == 4'hF)
        else $error("tracking channels disagree");
    chk_shared_off: assert property (mode_q != MODE_INDEP && |trip |-> ##1 gate_q == 4'h0)
        else $error("shared fault left a gate on");
    chk_slow_ignored: assert property (st_q[2] == CH_START && sy.slow_oc[2] && cond[2]
        |=> gate_q[2])
        else $error("slow comparator acted in window");
    chk_limit_cause: assert property (ilim_q[1] |-> $past(sy.fast_oc[1]) && gate_q[1])
        else $error("current cap without fast comparator");
    chk_good_drop: assert property (!sy.enable_level[0] |=> !good_q[0])
        else $error("good stayed with enable low");
    chk_latch_hold: assert property (st_q[1] == CH_FAULT && !auto_q && !clr[1]
        |=> st_q[1] == CH_FAULT [*1] ##0 !gate_q[1])
        else $error("latched channel left fault");
    chk_indep_alone: assert property (mode_q == MODE_INDEP && trip[2] && cond[1] && gate_q[1]
        && !trip[1] |=> gate_q[1])
        else $error("independent fault spread");
    // reset value is a parameter, so only software writes are range checked
    chk_len_range: assert property (wr && paddr == REG_START
        |=> len_q >= START_MIN_CYC && len_q <= START_MAX_CYC)
        else $error("startup length out of range");

    cov_track_all_on: cover property (mode_q == MODE_TRACK && gate_q == 4'hF);
    cov_fault_clear:  cover property (st_q[0] == CH_FAULT ##[1:200] st_q[0] == CH_OFF);
    cov_retry:        cover property (st_q[2] == CH_RETRY);
endmodule // hsq_ctrl

// ---- verilog/hsq_pkg.sv ----
package hsq_pkg;
    localparam int CLK_MHZ        = 125;
    localparam int T_LOCKOUT_US   = 37500;
    localparam int T_START_DEF_US = 9000;
    localparam int T_START_MIN_US = 400;
    localparam int T_START_MAX_US = 50000;
    localparam int T_REARM_US     = 100;
    localparam logic [22:0] LOCKOUT_CYC   = 23'(T_LOCKOUT_US * CLK_MHZ);
    localparam logic [22:0] START_DEF_CYC = 23'(T_START_DEF_US * CLK_MHZ);
    localparam logic [22:0] START_MIN_CYC = 23'(T_START_MIN_US * CLK_MHZ);
    localparam logic [22:0] START_MAX_CYC = 23'(T_START_MAX_US * CLK_MHZ);
    localparam int RETRY_SHIFT    = 6;
    localparam int NCH            = 4;
    localparam int TW             = 29;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_START  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    // field positions
    localparam int CTRL_AUTO_BIT  = 0;
    localparam int ST_MODE_LSB    = 0;
    localparam int ST_FIXED_BIT   = 2;
    localparam int ST_LOCK_BIT    = 3;
    localparam int ST_GATE_LSB    = 4;
    localparam int ST_START_LSB   = 8;
    localparam int ST_FAULT_LSB   = 12;
    localparam int ST_GOOD_LSB    = 16;
    localparam logic CTRL_AUTO_RST = 1'b0;

    typedef enum logic [1:0] {MODE_TRACK, MODE_SEQ, MODE_INDEP} hsq_mode_type;
    typedef enum logic [2:0] {CH_OFF, CH_START, CH_RUN, CH_FAULT, CH_RETRY} hsq_chan_type;

    function automatic hsq_mode_type hsq_decode_mode(input logic hi, input logic lo);
        if (hi) return MODE_TRACK;
        if (lo) return MODE_INDEP;
        return MODE_SEQ;
    endfunction

    function automatic logic [22:0] hsq_clamp_len(input logic [22:0] v);
        if (v < START_MIN_CYC) return START_MIN_CYC;
        if (v > START_MAX_CYC) return START_MAX_CYC;
        return v;
    endfunction
endpackage

// ---- verilog/hsq_sync.sv ----
`timescale 1ns/1ps
module hsq_sync (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // raw front end
    input  wire logic [3:0] lockout_in,
    input  wire logic [3:0] rail_in,
    input  wire logic [3:0] enable_in,
    input  wire logic [3:0] fast_oc_in,
    input  wire logic [3:0] slow_oc_in,
    input  wire logic       mode_hi_in,
    input  wire logic       mode_lo_in,
    input  wire logic       flag_sense_gnd_in,
    // synchronised side
    hsq_sync_if.src         sy
);
    import hsq_pkg::*;
    logic [22:0] meta_q;
    logic [22:0] meta_d;
    logic [22:0] stab_q;
    logic [22:0] stab_d;

    always_comb begin
        meta_d = {lockout_in, rail_in, enable_in, fast_oc_in, slow_oc_in,
                  mode_hi_in, mode_lo_in, flag_sense_gnd_in};
        stab_d = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 23'h000000;
            stab_q <= 23'h000000;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign {sy.lockout_level, sy.rail_present_level, sy.enable_level, sy.fast_oc,
            sy.slow_oc, sy.mode_hi, sy.mode_lo, sy.flag_sense_gnd} = stab_q;
endmodule // hsq_sync

// ---- verilog/hsq_sync_if.sv ----
`timescale 1ns/1ps
interface hsq_sync_if;
    logic [3:0] lockout_level;
    logic [3:0] rail_present_level;
    logic [3:0] enable_level;
    logic [3:0] fast_oc;
    logic [3:0] slow_oc;
    logic       mode_hi;
    logic       mode_lo;
    logic       flag_sense_gnd;
    modport src (output lockout_level, rail_present_level, enable_level, fast_oc,
                 slow_oc, mode_hi, mode_lo, flag_sense_gnd);
    modport dst (input lockout_level, rail_present_level, enable_level, fast_oc,
                 slow_oc, mode_hi, mode_lo, flag_sense_gnd);
endinterface

// ---- verilog/hsq_timer.sv ----
`timescale 1ns/1ps
module hsq_timer (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // control
    input  wire logic          load,
    input  wire logic [28:0]   value,
    // status
    output logic               expire
);
    import hsq_pkg::*;
    logic [TW-1:0] cnt_q;
    logic [TW-1:0] cnt_d;

    // load of n gives expire on the n-th cycle after
    always_comb begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = value;
        else if (cnt_q != '0)
            cnt_d = cnt_q - 29'h00000001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign expire = !load && (cnt_q == 29'h00000001);
endmodule // hsq_timer
